// ### design/cx_exec.sv
// Behaviour
// - Result is first operand AND NOT second
// - And-inverted zero update: Z when result zero
// - And-inverted carry update: C is odd parity
// - Result stored unless store suppressed
// - Second operand: register or 9-bit literal
// - Jump-and-link opcode 010111, four cycles
// - Link writes PC+1 into bits 8:0
// - Then PC loads the source address
// - No stack; exit jump uses patched field
// - Link: C unless PC+1 zero; Z when PC+1 zero
// - Clock mode gets destination's low byte
// - Clock-mode op: opcode 000011, source 0
// - Clock-mode op leaves frequency untouched
// - Executed hub op lasts 7 to 22 cycles
// - Hub op and compare store only if asked
// - Compare opcode 100001, four cycles
// - Compare: Z equal, C less than
// - Compare treats operands as unsigned
// - Forced store writes wrapped difference
// - And-inverted opcode 011001, four cycles
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cx_exec (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output var  logic [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // Hub arbiter and clock configuration
   input  wire logic          hub_grant,
   output cx_pkg::cx_hub_s    hub
);
   import cx_pkg::*;

   function automatic logic cx_hit(input logic [31:0] a,
                                   input logic [7:0]  off);
      cx_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
   endfunction

   function automatic logic cx_cond(input logic [3:0] cond,
                                    input logic       c,
                                    input logic       z);
      cx_cond = cond[{c, z}];
   endfunction

   cx_state_e          state_q, state_d;
   logic [31:0]        instr_q;
   logic [CADDR_W-1:0] pc_q;
   logic               z_q;
   logic               c_q;
   logic               illegal_q;
   logic               skip_q;
   logic [CNT_W-1:0]   cnt_q;
   logic [CNT_W-1:0]   last_cnt_q;
   logic [CADDR_W-1:0] ram_addr_q;
   logic [7:0]         clk_mode_q;
   logic               mode_we_q;
   logic [31:0]        prdata_q;
   logic [DATA_W-1:0]  ram_q [RAM_WORDS];

   // Bus decode
   wire cx_instr_s ins        = cx_instr_s'(instr_q);
   wire logic      busy       = (state_q != ST_IDLE);
   wire logic      acc        = psel & penable;
   wire logic      hit_instr  = cx_hit(paddr, OFF_INSTR);
   wire logic      hit_pc     = cx_hit(paddr, OFF_PC);
   wire logic      hit_flags  = cx_hit(paddr, OFF_FLAGS);
   wire logic      hit_status = cx_hit(paddr, OFF_STATUS);
   wire logic      hit_raddr  = cx_hit(paddr, OFF_RAMADDR);
   wire logic      hit_rdata  = cx_hit(paddr, OFF_RAMDATA);
   wire logic      hit_clkm   = cx_hit(paddr, OFF_CLKMODE);
   wire logic      hit_cyc    = cx_hit(paddr, OFF_CYCLES);
   wire logic      mapped     = hit_instr | hit_pc | hit_flags |
                                hit_status | hit_raddr | hit_rdata |
                                hit_clkm | hit_cyc;
   wire logic      guarded    = hit_instr | hit_pc | hit_flags |
                                hit_rdata;
   wire logic      bad        = ~mapped | (pwrite & busy & guarded);
   wire logic      wr_ok      = acc & pwrite & ~bad;
   wire logic      issue      = wr_ok & hit_instr;

   // Operand fetch
   wire logic [31:0] d_val = ram_q[ins.dest];
   wire logic [31:0] s_val = ins.imm ? {23'h00_0000, ins.src}
                                     : ram_q[ins.src];

   // Decode of the issued word
   wire cx_instr_s new_ins  = cx_instr_s'(pwdata);
   wire logic      new_hub  = (new_ins.opcode == OP_HUB) & new_ins.imm &
                              (new_ins.src == HUB_SEL_CLKMODE);
   wire logic      new_run  = cx_cond(new_ins.cond, c_q, z_q);
   wire logic      is_ainv  = (ins.opcode == OP_AND_INVERTED);
   wire logic      is_jmp   = (ins.opcode == OP_JUMP_AND_LINK);
   wire logic      is_clk   = (ins.opcode == OP_HUB) & ins.imm &
                              (ins.src == HUB_SEL_CLKMODE);
   wire logic      is_cmp   = (ins.opcode == OP_CMP_UNSIGNED);
   wire logic      legal    = is_ainv | is_jmp | is_clk | is_cmp;
   wire logic      run_ok   = ~skip_q & legal;

   // Datapath
   wire logic [31:0] ainv_res = d_val & ~s_val;
   wire logic [CADDR_W-1:0] pc_inc = pc_q + 9'h001;
   wire logic [31:0] jmp_res  = {d_val[31:9], pc_inc};
   wire logic [31:0] cmp_res  = d_val - s_val;
   wire logic        cmp_lt   = d_val < s_val;
   wire logic [31:0] clk_res  = {24'h00_0000, d_val[7:0]};

   logic [31:0] res;
   logic        z_new;
   logic        c_new;
   always_comb begin
      res   = d_val;
      z_new = z_q;
      c_new = c_q;
      case (1'b1)
         is_ainv: begin
            res   = ainv_res;
            z_new = (ainv_res == 32'h0000_0000);
            c_new = ^ainv_res;
         end
         is_jmp: begin
            res   = jmp_res;
            z_new = (pc_inc == 9'h000);
            c_new = (pc_inc != 9'h000);
         end
         is_cmp: begin
            res   = cmp_res;
            z_new = (d_val == s_val);
            c_new = cmp_lt;
         end
         is_clk: begin
            res   = clk_res;
            z_new = (clk_res == 32'h0000_0000);
            c_new = 1'b0;
         end
         default: begin
            res   = d_val;
         end
      endcase
   end

   // Sequencing
   wire logic alu_end = (state_q == ST_ALU) & (cnt_q == ALU_CYCLES - 8'h01);
   wire logic hub_end = (state_q == ST_HUB) & hub_grant &
                        (cnt_q >= HUB_MIN_CYCLES - 8'h01);
   wire logic commit  = alu_end | hub_end;
   wire logic do_st   = commit & run_ok & ins.wr;
   wire logic do_jmp  = commit & run_ok & is_jmp;
   wire logic [CADDR_W-1:0] pc_next = do_jmp ? s_val[8:0]
                                             : pc_inc;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (issue)
               state_d = (new_hub & new_run) ? ST_HUB : ST_ALU;
         end
         ST_ALU: begin
            if (alu_end)
               state_d = ST_IDLE;
         end
         ST_HUB: begin
            if (hub_end)
               state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 8'h00;
         last_cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (issue)
            cnt_q <= 8'h00;
         else if (busy && cnt_q != 8'hFF)
            cnt_q <= cnt_q + 8'h01;
         if (commit)
            last_cnt_q <= cnt_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q   <= INSTR_RST;
         illegal_q <= 1'b0;
         skip_q    <= 1'b0;
      end else if (issue) begin
         instr_q   <= pwdata;
         skip_q    <= ~new_run;
         illegal_q <= 1'b0;
      end else if (commit) begin
         illegal_q <= ~legal;
      end
   end

   // Program counter and flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= PC_RST;
         z_q  <= 1'b0;
         c_q  <= 1'b0;
      end else if (commit) begin
         pc_q <= pc_next;
         if (run_ok && ins.upd_z)
            z_q <= z_new;
         if (run_ok && ins.upd_c)
            c_q <= c_new;
      end else begin
         if (wr_ok && hit_pc)
            pc_q <= pwdata[8:0];
         if (wr_ok && hit_flags) begin
            z_q <= pwdata[FLAG_Z_BIT];
            c_q <= pwdata[FLAG_C_BIT];
         end
      end
   end

   // Cog memory; the link store patches the exit jump's source field
   always_ff @(posedge pclk) begin
      if (do_st)
         ram_q[ins.dest] <= res;
      else if (wr_ok && hit_rdata)
         ram_q[ram_addr_q] <= pwdata;
   end

   // Clock mode hand-off; no frequency value is held or touched here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_mode_q <= CLKM_RST;
         mode_we_q  <= 1'b0;
         ram_addr_q <= 9'h000;
      end else begin
         mode_we_q <= hub_end & run_ok;
         if (hub_end && run_ok)
            clk_mode_q <= d_val[7:0];
         if (wr_ok && hit_raddr)
            ram_addr_q <= pwdata[8:0];
      end
   end

   assign hub.req     = (state_q == ST_HUB);
   assign hub.mode_we = mode_we_q;
   assign hub.mode    = clk_mode_q;

   // Read data captured in the setup phase
   wire logic [31:0] status_w = {29'h0000_0000, skip_q, illegal_q, busy};
   wire logic [31:0] rd_mux =
      hit_instr  ? instr_q :
      hit_pc     ? {23'h00_0000, pc_q} :
      hit_flags  ? {30'h0000_0000, c_q, z_q} :
      hit_status ? status_w :
      hit_raddr  ? {23'h00_0000, ram_addr_q} :
      hit_rdata  ? ram_q[ram_addr_q] :
      hit_clkm   ? {24'h00_0000, clk_mode_q} :
      hit_cyc    ? {24'h00_0000, last_cnt_q} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata_q <= rd_mux;
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = acc & bad;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_four_busy;
      busy [*4] ##1 !busy;
   endsequence

   sequence s_alu_start;
      $rose(busy) && !skip_q;
   endsequence

   property p_ainv_res;
      commit && run_ok && is_ainv && ins.wr |=>
         ram_q[$past(ins.dest)] == ($past(d_val) & ~$past(s_val));
   endproperty
   a_ainv_res: assert property (p_ainv_res)
      else $error("and-inverted result wrong");

   property p_ainv_z;
      commit && run_ok && is_ainv && ins.upd_z |=>
         z_q == ($past(ainv_res) == 32'h0000_0000);
   endproperty
   a_ainv_z: assert property (p_ainv_z)
      else $error("and-inverted zero flag wrong");

   property p_ainv_c;
      commit && run_ok && is_ainv && ins.upd_c |=> c_q == ^$past(ainv_res);
   endproperty
   a_ainv_c: assert property (p_ainv_c)
      else $error("and-inverted carry flag wrong");

   property p_no_store;
      commit && !ins.wr |=> ram_q[$past(ins.dest)] == $past(d_val);
   endproperty
   a_no_store: assert property (p_no_store)
      else $error("destination changed without store");

   property p_jmp_time;
      s_alu_start and is_jmp |-> s_four_busy;
   endproperty
   a_jmp_time: assert property (p_jmp_time)
      else $error("jump-and-link not four cycles");

   property p_jmp_link;
      commit && run_ok && is_jmp && ins.wr |=>
         ram_q[$past(ins.dest)] == {$past(d_val[31:9]), $past(pc_inc)};
   endproperty
   a_jmp_link: assert property (p_jmp_link)
      else $error("return address not linked");

   property p_jmp_target;
      commit && run_ok && is_jmp |=> pc_q == $past(s_val[8:0]);
   endproperty
   a_jmp_target: assert property (p_jmp_target)
      else $error("jump target not loaded");

   property p_jmp_c;
      commit && run_ok && is_jmp && ins.upd_c |=>
         c_q == ($past(pc_q) != 9'h1FF);
   endproperty
   a_jmp_c: assert property (p_jmp_c)
      else $error("link carry flag wrong");

   property p_clk_mode;
      hub_end && run_ok |=> hub.mode == $past(d_val[7:0]) && hub.mode_we;
   endproperty
   a_clk_mode: assert property (p_clk_mode)
      else $error("clock mode not written");

   property p_hub_min;
      $rose(hub.req) |-> hub.req [*7];
   endproperty
   a_hub_min: assert property (p_hub_min)
      else $error("hub op shorter than seven cycles");

   property p_hub_max;
      $rose(hub.req) |-> ##[7:22] !hub.req;
   endproperty
   a_hub_max: assert property (p_hub_max)
      else $error("hub op longer than twenty-two cycles");

   property p_cmp_time;
      s_alu_start and is_cmp |-> s_four_busy;
   endproperty
   a_cmp_time: assert property (p_cmp_time)
      else $error("compare not four cycles");

   property p_cmp_c;
      commit && run_ok && is_cmp && ins.upd_c |=>
         c_q == ($past(d_val) < $past(s_val));
   endproperty
   a_cmp_c: assert property (p_cmp_c)
      else $error("compare carry flag wrong");

   property p_cmp_diff;
      commit && run_ok && is_cmp && ins.wr |=>
         ram_q[$past(ins.dest)] == $past(d_val) - $past(s_val);
   endproperty
   a_cmp_diff: assert property (p_cmp_diff)
      else $error("compare difference wrong");

   property p_flag_keep;
      commit && !ins.upd_z |=> $stable(z_q);
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("zero flag changed without effect");

endmodule

`default_nettype wire

// ### design/cx_pkg.sv
package cx_pkg;

   // Datapath and cog memory geometry
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned CADDR_W   = 9;
   localparam int unsigned RAM_WORDS = 512;
   localparam int unsigned CNT_W     = 8;

   // Opcode, source and condition field values
   localparam logic [5:0] OP_AND_INVERTED  = 6'h19;
   localparam logic [5:0] OP_JUMP_AND_LINK = 6'h17;
   localparam logic [5:0] OP_HUB           = 6'h03;
   localparam logic [5:0] OP_CMP_UNSIGNED  = 6'h21;
   localparam logic [8:0] HUB_SEL_CLKMODE  = 9'h000;
   localparam logic [3:0] COND_ALWAYS      = 4'hF;

   // Execution times in clock cycles
   localparam logic [CNT_W-1:0] ALU_CYCLES     = 8'h04;
   localparam logic [CNT_W-1:0] HUB_MIN_CYCLES = 8'h07;
   localparam logic [CNT_W-1:0] HUB_MAX_CYCLES = 8'h16;

   // APB register byte offsets
   localparam logic [7:0] OFF_INSTR   = 8'h00;
   localparam logic [7:0] OFF_PC      = 8'h04;
   localparam logic [7:0] OFF_FLAGS   = 8'h08;
   localparam logic [7:0] OFF_STATUS  = 8'h0C;
   localparam logic [7:0] OFF_RAMADDR = 8'h10;
   localparam logic [7:0] OFF_RAMDATA = 8'h14;
   localparam logic [7:0] OFF_CLKMODE = 8'h18;
   localparam logic [7:0] OFF_CYCLES  = 8'h1C;

   // Field positions
   localparam int unsigned FLAG_Z_BIT     = 0;
   localparam int unsigned FLAG_C_BIT     = 1;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_ILLEGAL_BIT = 1;
   localparam int unsigned ST_SKIP_BIT    = 2;

   // Values after reset
   localparam logic [31:0]        INSTR_RST = 32'h0000_0000;
   localparam logic [CADDR_W-1:0] PC_RST    = 9'h000;
   localparam logic [7:0]         CLKM_RST  = 8'h00;

   typedef struct packed {
      logic [5:0]         opcode;
      logic               upd_z;
      logic               upd_c;
      logic               wr;
      logic               imm;
      logic [3:0]         cond;
      logic [CADDR_W-1:0] dest;
      logic [CADDR_W-1:0] src;
   } cx_instr_s;

   typedef struct packed {
      logic       req;
      logic       mode_we;
      logic [7:0] mode;
   } cx_hub_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ALU  = 3'b010,
      ST_HUB  = 3'b100
   } cx_state_e;

endpackage

// ### dv/cx_hub_model.sv
`timescale 1ns/10ps
`default_nettype none

module cx_hub_model (
   // Clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // Core side
   input  wire cx_pkg::cx_hub_s hub,
   output logic                 hub_grant,
   // Clock configuration register
   output logic [7:0]           clk_mode_q
);
   import cx_pkg::*;

   logic [3:0] slot_q;

   // One window cycle in every sixteen, so a wait lasts 7 to 22 cycles
   assign hub_grant = (slot_q == 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q     <= 4'h0;
         clk_mode_q <= 8'h00;
      end else begin
         slot_q <= slot_q + 4'h1;
         if (hub.mode_we) begin
            clk_mode_q <= hub.mode;
         end
      end
   end
endmodule

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
   import cx_pkg::*;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        hub_grant;
   cx_hub_s     hub;
   logic [7:0]  clk_mode;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          num_checks;

   logic [31:0] an_s [3] = '{32'hFFFF_FFFA, 32'hFFFF_FFF8, 32'hFFFF_FFF0};
   logic [31:0] an_r [3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_000A};
   logic [1:0]  an_f [3] = '{2'h1, 2'h2, 2'h0};
   logic [31:0] cm_d [8] = '{32'h3, 32'h3, 32'h3, 32'h8000_0000,
      32'h7FFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFE, 32'hFFFF_FFFE};
   logic [31:0] cm_s [8] = '{32'h2, 32'h3, 32'h4, 32'h7FFF_FFFF,
      32'h8000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFD};
   logic [31:0] cm_r [8] = '{32'h1, 32'h0, 32'hFFFF_FFFF, 32'h1,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h1};
   logic [1:0]  cm_f [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};

   cx_exec i_cx_exec (
      .pclk      (pclk),
      .presetn   (presetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .hub_grant (hub_grant),
      .hub       (hub)
   );

   cx_hub_model i_cx_hub_model (
      .pclk       (pclk),
      .presetn    (presetn),
      .hub        (hub),
      .hub_grant  (hub_grant),
      .clk_mode_q (clk_mode)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {24'h0, a};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask

   task automatic ramwr(input logic [8:0] a, input logic [31:0] d);
      apb(1'b1, OFF_RAMADDR, {23'h0, a});
      apb(1'b1, OFF_RAMDATA, d);
   endtask

   task automatic ramchk(input string nm, input logic [8:0] a,
                         input logic [31:0] exp);
      apb(1'b1, OFF_RAMADDR, {23'h0, a});
      rdchk(nm, OFF_RAMDATA, exp);
   endtask

   task automatic flgchk(input string nm, input logic [1:0] exp);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk(nm, {30'h0, rd[1:0]}, {30'h0, exp});
   endtask

   // Issue one instruction word and poll until the core is idle again
   task automatic issue_wait(input logic [31:0] w);
      int n;
      apb(1'b1, OFF_INSTR, w);
      n = 0;
      do begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 20);
      if (n >= 20) begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic run(input logic [5:0] op, input logic [3:0] zcri,
                      input logic [8:0] d, input logic [8:0] s);
      issue_wait({op, zcri, COND_ALWAYS, d, s});
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      fails = 0;
      num_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("pc_rst", OFF_PC, 32'h0);
      rdchk("clk_rst", OFF_CLKMODE, 32'h0);
      rdchk("unmapped", 8'h20, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         ramwr(9'h00A, 32'hF731_125A);
         ramwr(9'h00B, an_s[i]);
         run(OP_AND_INVERTED, 4'hE, 9'h00A, 9'h00B);
         ramchk("ainv_res", 9'h00A, an_r[i]);
         flgchk("ainv_flg", an_f[i]);
         rdchk("ainv_cyc", OFF_CYCLES, 32'h4);
      end
      apb(1'b1, OFF_FLAGS, 32'h3);
      ramwr(9'h00A, 32'hFFFF_FFFF);
      run(OP_AND_INVERTED, 4'h3, 9'h00A, 9'h1F0);
      ramchk("ainv_imm", 9'h00A, 32'hFFFF_FE0F);
      flgchk("keep_flg", 2'h3);
      run(OP_AND_INVERTED, 4'hD, 9'h00A, 9'h00F);
      ramchk("ainv_nost", 9'h00A, 32'hFFFF_FE0F);
      flgchk("ainv_nost_flg", 2'h2);
      // Condition field all zeros never executes
      issue_wait({OP_AND_INVERTED, 4'hE, 4'h0, 9'h00A, 9'h00F});
      chk("skip_st", rd, 32'h4);
      ramchk("skip_nost", 9'h00A, 32'hFFFF_FE0F);
      flgchk("skip_flg", 2'h2);
      for (int i = 0; i < 8; i++) begin
         ramwr(9'h010, cm_d[i]);
         ramwr(9'h011, cm_s[i]);
         run(OP_CMP_UNSIGNED, 4'hE, 9'h010, 9'h011);
         ramchk("cmp_res", 9'h010, cm_r[i]);
         flgchk("cmp_flg", cm_f[i]);
         rdchk("cmp_cyc", OFF_CYCLES, 32'h4);
      end
      ramwr(9'h010, 32'h3);
      run(OP_CMP_UNSIGNED, 4'hD, 9'h010, 9'h004);
      ramchk("cmp_nostore", 9'h010, 32'h3);
      flgchk("cmp_imm_flg", 2'h2);
      apb(1'b1, OFF_PC, 32'h020);
      ramwr(9'h005, 32'hABCD_E000);
      run(OP_JUMP_AND_LINK, 4'hF, 9'h005, 9'h040);
      ramchk("link_ret", 9'h005, 32'hABCD_E021);
      rdchk("link_pc", OFF_PC, 32'h040);
      flgchk("link_flg", 2'h2);
      rdchk("link_cyc", OFF_CYCLES, 32'h4);
      apb(1'b1, OFF_PC, 32'h100);
      run(OP_JUMP_AND_LINK, 4'hF, 9'h005, 9'h040);
      ramchk("link_nest", 9'h005, 32'hABCD_E101);
      run(OP_JUMP_AND_LINK, 4'h0, 9'h00A, 9'h005);
      rdchk("exit_pc", OFF_PC, 32'h101);
      apb(1'b1, OFF_PC, 32'h1FF);
      run(OP_JUMP_AND_LINK, 4'hF, 9'h005, 9'h040);
      ramchk("link_wrap", 9'h005, 32'hABCD_E000);
      flgchk("link_wrap_flg", 2'h1);
      // Varying gaps move the issue point around the hub window
      for (int k = 0; k < 3; k++) begin
         ramwr(9'h007, 32'h0000_1A60 + k);
         repeat (k * 5) @(posedge pclk);
         run(OP_HUB, 4'h1, 9'h007, HUB_SEL_CLKMODE);
         apb(1'b0, OFF_CYCLES, 32'h0);
         chk("hub_cyc", {31'h0, rd[7:0] >= 8'h07 && rd[7:0] <= 8'h16},
             32'h1);
         rdchk("clk_mode", OFF_CLKMODE, 32'h60 + k);
         chk("clk_far", {24'h0, clk_mode}, 32'h60 + k);
         ramchk("hub_nostore", 9'h007, 32'h1A60 + k);
      end
      ramwr(9'h007, 32'h0000_0055);
      run(OP_HUB, 4'h1, 9'h007, 9'h001);
      chk("hub_other", {31'h0, rd[ST_ILLEGAL_BIT]}, 32'h1);
      rdchk("clk_keep", OFF_CLKMODE, 32'h62);
      run(OP_HUB, 4'hF, 9'h007, HUB_SEL_CLKMODE);
      ramchk("hub_store", 9'h007, 32'h55);
      flgchk("hub_flg", 2'h0);
      chk("clk_far2", {24'h0, clk_mode}, 32'h55);
      tally_and_finish();
   end
endmodule

`default_nettype wire
